// *** equalizer_fir_config.sv ***
// Operation
// - Mode 0 disables, mode 2 enables filter
// - Share bit gives channel B channel A coefficients
// - Merge bit forms one filter, one stream
// - Side weight scales side taps by 2^(w-16)
// - Tap0 register holds 12-bit signed first tap
// - Tap1 register holds 12-bit signed second tap
// - Nine taps, centre coefficient 18-bit signed
// - Tap2 register holds 12-bit signed third tap
`default_nettype none
module equalizer_fir_config #(
  parameter int FIFO_DEPTH = eq_filter_pkg::FIFO_DEPTH
) (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic [11:0] reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_write_in,
  input  wire logic        reg_read_in,
  output logic [7:0]       reg_rdata_out,
  input  wire logic [3:0][11:0] chan_b_side_coef_in,
  input  wire logic [17:0] chan_b_center_coef_in,
  input  wire logic        sample_valid_in,
  output logic             sample_ready_out,
  input  wire logic [11:0] sample_a_in,
  input  wire logic [11:0] sample_b_in,
  output logic             stream_valid_out,
  input  wire logic        stream_ready_in,
  output logic [11:0]      stream_a_out,
  output logic [11:0]      stream_b_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0]        cfg;
    logic [3:0][11:0]  side;
    logic [17:0]       center;
    logic [17:0][11:0] hist;
    logic              pend;
    logic [7:0]        rdata;
  } cfg_state_type;

  cfg_state_type state_q;
  cfg_state_type state_d;

  logic [8:0][11:0] win_a;
  logic [8:0][11:0] win_b;
  logic [3:0][11:0] coef_b_side;
  logic [17:0]      coef_b_center;
  logic [11:0]      filt_a;
  logic [11:0]      filt_b;
  logic [11:0]      out_a;
  logic [11:0]      out_b;
  logic             fifo_ready;
  logic             accept;
  logic             enabled;
  logic             merged;
  logic             shared;
  logic [2:0]       weight;

  // ****************************************************************
  // Register read decode
  // ****************************************************************
  function automatic logic [7:0] read_byte(input cfg_state_type s,
                                           input logic [11:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == eq_filter_pkg::CFG_OFS) begin
      v = s.cfg & eq_filter_pkg::CFG_WMASK;
    end
    for (int k = 0; k < eq_filter_pkg::NUM_SIDE; k++) begin
      if (a == eq_filter_pkg::TAP0_OFS + 12'(2 * k)) begin
        v = s.side[k][7:0];
      end
      if (a == eq_filter_pkg::TAP0_OFS + 12'(2 * k + 1)) begin
        // Upper nibble reads zero; only 12 bits are held
        v = {4'h0, s.side[k][11:8]};
      end
    end
    if (a == eq_filter_pkg::CENTER_OFS) begin
      v = s.center[7:0];
    end
    if (a == eq_filter_pkg::CENTER_OFS + 12'h001) begin
      v = s.center[15:8];
    end
    if (a == eq_filter_pkg::CENTER_OFS + 12'h002) begin
      v = {6'h00, s.center[17:16]};
    end
    return v;
  endfunction

  // ****************************************************************
  // Decoded configuration
  // ****************************************************************
  // Reserved mode codes 1 and 3 fall back to bypass
  assign enabled = (state_q.cfg[eq_filter_pkg::MODE_MSB:
                    eq_filter_pkg::MODE_LSB] ==
                    eq_filter_pkg::MODE_ENABLED);
  assign merged  = state_q.cfg[eq_filter_pkg::MERGE_BIT];
  assign shared  = state_q.cfg[eq_filter_pkg::SHARE_BIT];
  assign weight  = state_q.cfg[eq_filter_pkg::SCW_MSB:
                               eq_filter_pkg::SCW_LSB];

  // ****************************************************************
  // Sample windows
  // ****************************************************************
  // History holds b_n, a_n, b_n-1, a_n-1, ... newest first; in merged
  // mode both lanes read one interleaved stream with A sampled first.
  always_comb begin
    for (int k = 0; k < eq_filter_pkg::NUM_TAPS; k++) begin
      if (merged) begin
        win_a[k] = state_q.hist[k + 1];
        win_b[k] = state_q.hist[k];
      end else begin
        win_a[k] = state_q.hist[2 * k + 1];
        win_b[k] = state_q.hist[2 * k];
      end
    end
  end

  // A merged filter is one logical filter, so it takes one set
  assign coef_b_side   = (shared || merged) ? state_q.side
                                            : chan_b_side_coef_in;
  assign coef_b_center = (shared || merged) ? state_q.center
                                            : chan_b_center_coef_in;

  tap_scaler u_tap_a (
    .samples_in          (win_a),
    .side_coef_in        (state_q.side),
    .center_coef_in      (state_q.center),
    .side_coef_weight_in (weight),
    .result_out          (filt_a)
  );

  tap_scaler u_tap_b (
    .samples_in          (win_b),
    .side_coef_in        (coef_b_side),
    .center_coef_in      (coef_b_center),
    .side_coef_weight_in (weight),
    .result_out          (filt_b)
  );

  assign out_a = enabled ? filt_a : state_q.hist[1];
  assign out_b = enabled ? filt_b : state_q.hist[0];

  // ****************************************************************
  // Stream handshake
  // ****************************************************************
  // One result waits per slot; a full FIFO stalls the sample source
  assign sample_ready_out = !state_q.pend || fifo_ready;
  assign accept           = sample_valid_in && sample_ready_out;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    if (reg_write_in) begin
      if (reg_addr_in == eq_filter_pkg::CFG_OFS) begin
        state_d.cfg = reg_wdata_in & eq_filter_pkg::CFG_WMASK;
      end
      for (int k = 0; k < eq_filter_pkg::NUM_SIDE; k++) begin
        if (reg_addr_in == eq_filter_pkg::TAP0_OFS + 12'(2 * k)) begin
          state_d.side[k][7:0] = reg_wdata_in;
        end
        if (reg_addr_in == eq_filter_pkg::TAP0_OFS + 12'(2 * k + 1)) begin
          state_d.side[k][11:8] = reg_wdata_in[3:0];
        end
      end
      if (reg_addr_in == eq_filter_pkg::CENTER_OFS) begin
        state_d.center[7:0] = reg_wdata_in;
      end
      if (reg_addr_in == eq_filter_pkg::CENTER_OFS + 12'h001) begin
        state_d.center[15:8] = reg_wdata_in;
      end
      if (reg_addr_in == eq_filter_pkg::CENTER_OFS + 12'h002) begin
        state_d.center[17:16] = reg_wdata_in[1:0];
      end
    end
    if (reg_read_in) begin
      state_d.rdata = read_byte(state_q, reg_addr_in);
    end
    if (state_q.pend && fifo_ready) begin
      state_d.pend = 1'b0;
    end
    if (accept) begin
      for (int i = eq_filter_pkg::HIST_LEN - 1; i >= 2; i--) begin
        state_d.hist[i] = state_q.hist[i - 2];
      end
      state_d.hist[1] = sample_a_in;
      state_d.hist[0] = sample_b_in;
      state_d.pend    = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q        <= '0;
      state_q.cfg    <= eq_filter_pkg::CFG_RESET;
      state_q.side   <= {4{eq_filter_pkg::SIDE_RESET}};
      state_q.center <= eq_filter_pkg::CENTER_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign reg_rdata_out = state_q.rdata;

  // ****************************************************************
  // Output buffer
  // ****************************************************************
  sample_fifo #(
    .WIDTH (24),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .rstn_in       (rstn_in),
    .in_valid_in   (state_q.pend),
    .in_ready_out  (fifo_ready),
    .in_data_in    ({out_b, out_a}),
    .out_valid_out (stream_valid_out),
    .out_ready_in  (stream_ready_in),
    .out_data_out  ({stream_b_out, stream_a_out})
  );

endmodule
`default_nettype wire

// *** eq_filter_pkg.sv ***
`default_nettype none
package eq_filter_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int ADDR_W    = 12;
  localparam int SAMPLE_W  = 12;
  localparam int SIDE_W    = 12;
  localparam int CENTER_W  = 18;
  localparam int NUM_TAPS  = 9;
  localparam int NUM_SIDE  = 4;
  localparam int HIST_LEN  = 18;
  localparam int FRAC_BITS = 16;
  localparam int FIFO_DEPTH = 8;

  // ****************************************************************
  // Byte offsets
  // ****************************************************************
  localparam logic [11:0] CFG_OFS    = 12'h400;
  localparam logic [11:0] TAP0_OFS   = 12'h418;
  localparam logic [11:0] TAP1_OFS   = 12'h41A;
  localparam logic [11:0] TAP2_OFS   = 12'h41C;
  localparam logic [11:0] TAP3_OFS   = 12'h41E;
  localparam logic [11:0] CENTER_OFS = 12'h420;

  // ****************************************************************
  // Fields of the configuration byte
  // ****************************************************************
  localparam int MODE_LSB  = 0;
  localparam int MODE_MSB  = 1;
  localparam int SCW_LSB   = 2;
  localparam int SCW_MSB   = 4;
  localparam int MERGE_BIT = 5;
  localparam int SHARE_BIT = 6;
  localparam logic [7:0] CFG_WMASK = 8'h7F;

  localparam logic [1:0] MODE_DISABLED = 2'h0;
  localparam logic [1:0] MODE_ENABLED  = 2'h2;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0]  CFG_RESET    = 8'h00;
  localparam logic [11:0] SIDE_RESET   = 12'h000;
  localparam logic [17:0] CENTER_RESET = 18'h00000;

endpackage
`default_nettype wire

// *** sample_fifo.sv ***
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [PW:0]                 cnt;
  } fifo_state_type;

  fifo_state_type state_q;
  fifo_state_type state_d;
  logic           push;
  logic           pop;

  assign in_ready_out  = (state_q.cnt != DEPTH[PW:0]);
  assign out_valid_out = (state_q.cnt != '0);
  assign out_data_out  = state_q.mem[state_q.rd];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_comb begin
    state_d = state_q;
    if (push) begin
      state_d.mem[state_q.wr] = in_data_in;
      state_d.wr = (state_q.wr == PW'(DEPTH - 1)) ? '0 : state_q.wr + 1'b1;
    end
    if (pop) begin
      state_d.rd = (state_q.rd == PW'(DEPTH - 1)) ? '0 : state_q.rd + 1'b1;
    end
    if (push && !pop) begin
      state_d.cnt = state_q.cnt + 1'b1;
    end else if (pop && !push) begin
      state_d.cnt = state_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

endmodule
`default_nettype wire

// *** tap_scaler.sv ***
`default_nettype none
module tap_scaler (
  input  wire logic [8:0][11:0] samples_in,
  input  wire logic [3:0][11:0] side_coef_in,
  input  wire logic [17:0]      center_coef_in,
  input  wire logic [2:0]       side_coef_weight_in,
  output logic [11:0]           result_out
);

  logic signed [35:0] side_acc;
  logic signed [35:0] center_prod;
  logic signed [35:0] total;
  logic signed [35:0] scaled;
  logic signed [12:0] pair;

  // ****************************************************************
  // Symmetric side taps share one coefficient per pair
  // ****************************************************************
  always_comb begin
    side_acc = '0;
    pair     = '0;
    for (int k = 0; k < 4; k++) begin
      pair = 13'($signed(samples_in[k])) +
             13'($signed(samples_in[8-k]));
      // Widen before the product so no partial product is cut short
      side_acc = side_acc + 36'(pair) * 36'($signed(side_coef_in[k]));
    end
    // Side LSB is 2^(weight-16); centre LSB stays 2^-16
    center_prod = 36'($signed(samples_in[4])) *
                  36'($signed(center_coef_in));
    total  = (side_acc <<< side_coef_weight_in) + center_prod;
    scaled = total >>> eq_filter_pkg::FRAC_BITS;
    if (scaled > 36'sd2047) begin
      result_out = 12'h7FF;
    end else if (scaled < -36'sd2048) begin
      result_out = 12'h800;
    end else begin
      result_out = scaled[11:0];
    end
  end

endmodule
`default_nettype wire

// *** equalizer_fir_config_assertions.sv ***
`default_nettype none
module equalizer_fir_config_checker (
  input wire logic        clk_in,
  input wire logic        rstn_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic [7:0]  reg_wdata_in,
  input wire logic        reg_write_in,
  input wire logic        reg_read_in,
  input wire logic [7:0]  reg_rdata_out,
  input wire logic        sample_valid_in,
  input wire logic        sample_ready_out,
  input wire logic        stream_valid_out,
  input wire logic        stream_ready_in,
  input wire logic [11:0] stream_a_out,
  input wire logic [11:0] stream_b_out
);
  logic [7:0] cfg_q;
  logic [7:0] lo_q;
  logic       take;
  assign take = sample_valid_in && sample_ready_out;
  // Mirror of bytes written to 12'h400 and 12'h418; bit 7 of the config byte is not stored
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cfg_q <= 8'h00;
      lo_q <= 8'h00;
    end else if (reg_write_in && reg_addr_in == 12'h400) begin
      cfg_q <= reg_wdata_in & 8'h7F;
    end else if (reg_write_in && reg_addr_in == 12'h418) begin
      lo_q <= reg_wdata_in;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  cfg_readback_a: assert property (
    reg_read_in && reg_addr_in == 12'h400 |=> reg_rdata_out == $past(cfg_q))
    else $error("config readback wrong");
  tap_readback_a: assert property (
    reg_read_in && reg_addr_in == 12'h418 |=> reg_rdata_out == $past(lo_q))
    else $error("tap low byte readback wrong");
  tap_nibble_a: assert property (
    reg_read_in && reg_addr_in inside {12'h419, 12'h41B, 12'h41D}
    |=> reg_rdata_out[7:4] == 4'h0) else $error("tap upper nibble set");
  unmapped_zero_a: assert property (
    reg_read_in && reg_addr_in == 12'h401 |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (
    !reg_read_in |=> $stable(reg_rdata_out)) else $error("rdata moved");
  stall_hold_a: assert property (
    stream_valid_out && !stream_ready_in |=> stream_valid_out &&
    $stable(stream_a_out) && $stable(stream_b_out))
    else $error("stream word dropped while stalled");
  take_latency_a: assert property (
    take && !stream_valid_out |-> ##2 stream_valid_out)
    else $error("result late");
  refuse_full_a: assert property (
    !sample_ready_out |-> stream_valid_out) else $error("refused while empty");
endmodule
bind equalizer_fir_config equalizer_fir_config_checker chk (.clk_in,
  .rstn_in, .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in,
  .reg_rdata_out, .sample_valid_in, .sample_ready_out, .stream_valid_out,
  .stream_ready_in, .stream_a_out, .stream_b_out);
`default_nettype wire

// *** link_sink_model.sv ***
`default_nettype none
module link_sink_model (
  input  wire logic clk_in,
  input  wire logic rstn_in,
  input  wire logic slow_in,
  output logic      ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  // Slow mode takes one word in sixteen so the FIFO backs up and refuses
  always @(negedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q <= 4'h0;
      ready_out <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      ready_out <= !slow_in || cnt_q == 4'hF;
    end
  end
endmodule
`default_nettype wire

// *** equalizer_fir_config_tb_top.sv ***
`default_nettype none
module equalizer_fir_config_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk_in = 0;
  logic              rstn_in = 0;
  logic [11:0]       reg_addr_in = 0;
  logic [7:0]        reg_wdata_in = 0;
  logic              reg_write_in = 0;
  logic              reg_read_in = 0;
  logic [7:0]        reg_rdata_out;
  logic [3:0][11:0]  chan_b_side_coef_in = {12'h000, 12'h000, 12'hF80,
                                            12'h080};
  logic [17:0]       chan_b_center_coef_in = 18'h08000;
  logic              sample_valid_in = 0;
  logic              sample_ready_out;
  logic [11:0]       sample_a_in = 0;
  logic [11:0]       sample_b_in = 0;
  logic              stream_valid_out;
  logic              stream_ready_in;
  logic [11:0]       stream_a_out;
  logic [11:0]       stream_b_out;
  logic              slow_in = 0;
  logic [31:0]       seed = 32'h00014D1C;
  int                failures = 0;
  int                n_checks = 0;
  int                cycles = 0;
  logic [23:0]       exp_w;
  logic [23:0]       seen_w;
  logic [23:0]       exp_q[$];
  int                ha[$];
  int                hb[$];
  int                hm[$];
  int                sd[4] = '{256, -256, 64, 0};
  logic [19:0]       prog[9] = '{20'h41800, 20'h41901, 20'h41A00, 20'h41B0F,
    20'h41C40, 20'h41D00, 20'h42000, 20'h42100, 20'h42201};
  logic [27:0]       regs[8] = '{28'h400F878, 28'h4185A5A, 28'h419FF0F,
    28'h41AA5A5, 28'h41BFF0F, 28'h41C3C3C, 28'h41DFF0F, 28'h401AB00};
  logic [7:0]        cfgs[7] = '{8'h00, 8'h01, 8'h03, 8'h1A, 8'h5A, 8'h3A,
    8'h0E};

  equalizer_fir_config dut (.clk_in, .rstn_in, .reg_addr_in, .reg_wdata_in,
    .reg_write_in, .reg_read_in, .reg_rdata_out, .chan_b_side_coef_in,
    .chan_b_center_coef_in, .sample_valid_in, .sample_ready_out,
    .sample_a_in, .sample_b_in, .stream_valid_out, .stream_ready_in,
    .stream_a_out, .stream_b_out);
  link_sink_model sink (.clk_in, .rstn_in, .slow_in,
    .ready_out(stream_ready_in));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  function automatic int fir(input int h[$], input int s[4], input int c,
                             input int w);
    longint acc;
    acc = longint'(c) * h[4];
    for (int k = 0; k < 4; k++) begin
      acc += (longint'(s[k]) * (h[k] + h[8 - k])) <<< w;
    end
    acc = acc >>> 16;
    if (acc > 2047) acc = 2047;
    if (acc < -2048) acc = -2048;
    return int'(acc);
  endfunction

  function automatic void push(ref int h[$], input int v);
    h.push_front(v);
    h = h[0:8];
  endfunction

  task automatic check(input string nm, input logic [23:0] seen,
                       input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic bus(input logic [11:0] a, input logic [7:0] d,
                     input logic w, input logic r);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_write_in = w;
    reg_read_in = r;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
    bus(a, 8'h00, 1'b0, 1'b1);
    bus(12'h000, 8'h00, 1'b0, 1'b0);
    check("rdata", {16'h0, reg_rdata_out}, {16'h0, e});
  endtask

  task automatic do_reset;
    @(negedge clk_in);
    rstn_in = 0;
    repeat (3) @(negedge clk_in);
    rstn_in = 1;
    ha = {};
    hb = {};
    hm = {};
    repeat (9) begin
      ha.push_back(0);
      hb.push_back(0);
      hm.push_back(0);
    end
  endtask

  // Coefficients go in before the mode byte, with the link side idle
  task automatic phase(input logic [7:0] c, input int n);
    int a;
    int b;
    int ea;
    int eb;
    int w;
    do_reset();
    w = int'(c[4:2]);
    slow_in = c == 8'h1A;
    foreach (prog[i]) bus(prog[i][19:8], prog[i][7:0], 1'b1, 1'b0);
    bus(12'h400, c, 1'b1, 1'b0);
    bus(12'h000, 8'h00, 1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      seed = xs(seed);
      a = $signed(seed[9:0]);
      b = $signed(seed[25:16]);
      @(negedge clk_in);
      sample_valid_in = 1;
      sample_a_in = 12'(a);
      sample_b_in = 12'(b);
      #1;
      while (!sample_ready_out) begin
        @(negedge clk_in);
        #1;
      end
      push(ha, a);
      push(hb, b);
      push(hm, a);
      ea = c[5] ? fir(hm, sd, 65536, w) : fir(ha, sd, 65536, w);
      push(hm, b);
      eb = c[6] ? fir(hb, sd, 65536, w)
                : fir(hb, '{128, -128, 0, 0}, 32768, w);
      if (c[5]) eb = fir(hm, sd, 65536, w);
      if (c[1:0] != 2'h2) exp_q.push_back({12'(b), 12'(a)});
      else exp_q.push_back({12'(eb), 12'(ea)});
      @(posedge clk_in);
    end
    @(negedge clk_in);
    sample_valid_in = 0;
    repeat (400) if (exp_q.size() > 0) @(negedge clk_in);
    check("drained", 24'(exp_q.size()), 24'h0);
  endtask

  // ****************************************************************
  // Clock, timeout, monitor, sequence
  // ****************************************************************
  always #5 clk_in = !clk_in;

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end

  always @(posedge clk_in) begin
    if (rstn_in && stream_valid_out && stream_ready_in) begin
      // An unexpected word compares against X and so always counts
      exp_w  = exp_q.size() > 0 ? exp_q.pop_front() : 24'hX;
      seen_w = {stream_b_out, stream_a_out};
      check("stream", seen_w, exp_w);
    end
  end

  initial begin
    do_reset();
    foreach (regs[i]) begin
      rdchk(regs[i][27:16], 8'h00);
      bus(regs[i][27:16], regs[i][15:8], 1'b1, 1'b0);
      rdchk(regs[i][27:16], regs[i][7:0]);
    end
    foreach (cfgs[i]) phase(cfgs[i], 24);
    complete_run();
  end
endmodule
`default_nettype wire
